// File: logic/stack_unit_pkg.sv
package stack_unit_pkg;
  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PUSH,
    OP_POP,
    OP_PUSH_SEL,
    OP_CALL,
    OP_RET,
    OP_ENTER,
    OP_LEAVE,
    OP_LOAD
  } stack_op_t;

  localparam int ADDR_W = 32;
  localparam int NARROW_W = 16;
  localparam int SEL_W = 16;
  localparam logic [31:0] STEP_NARROW = 32'h0000_0002;
  localparam logic [31:0] STEP_WIDE = 32'h0000_0004;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] NARROW_MAX = 16'hFFFF;
  localparam int NARROW_MASK_POS = 16;
  localparam logic [31:0] WIDE_ALIGN_MASK = 32'hFFFF_FFFC;
  // largest segment a stack may fill, in bytes
  localparam logic [32:0] MAX_SEG_BYTES = 33'h1_0000_0000;
endpackage

// File: logic/stack_addr_calc.sv
`timescale 1ns/1ps
`default_nettype none
// new pointer value for one push or pop step
module stack_addr_calc (
  input wire logic [31:0] i_sp,
  input wire logic [31:0] i_step,
  input wire logic i_down,
  input wire logic i_narrow,
  input wire logic i_align,
  output logic [31:0] o_sp
);
  import stack_unit_pkg::*;
  logic [31:0] base;
  logic [31:0] full;
  logic [15:0] low;

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  // selector push on wide stack drops to a 4-byte boundary first
  always_comb begin
    base = i_align ? (i_sp & WIDE_ALIGN_MASK) : i_sp;
    full = i_down ? (base - i_step) : (base + i_step);
    low = full[15:0];
    // narrow mode wraps in 16 bits, upper half kept
    if (i_narrow) begin
      o_sp = {i_sp[31:16], low};
    end else begin
      o_sp = full;
    end
  end
endmodule
`default_nettype wire

// File: logic/stack_pointer_push_pop_unit.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - push: decrement pointer, then write
// - pop: read top, then increment pointer
// - all stack addresses use stack segment
// - call/ret/push/pop/enter/leave use current stack
// - step size from code segment default flag
// - step is two or four bytes
// - selector push on wide stack aligns
// - other narrow pushes stay unaligned
// - no alignment check, no fault
// - explicit operand size from flag, prefix
// - narrow size uses 16-bit pointer
// - wide size uses full 32 bits
// - stack big flag picks pointer size
// - only one current stack exists
// - stack spans up to full segment
module stack_pointer_push_pop_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_op_valid,
  input wire stack_unit_pkg::stack_op_t i_op,
  input wire logic [31:0] i_push_data,
  input wire logic i_push_narrow,
  input wire logic i_code_dflag,
  input wire logic i_addr_prefix,
  input wire logic i_stack_bflag,
  input wire logic [15:0] i_load_sel,
  input wire logic [31:0] i_load_sp,
  input wire logic i_load_sel_en,
  input wire logic i_load_sp_en,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_rvalid,
  output logic o_busy,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [15:0] o_mem_seg,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  output logic [31:0] o_pop_data,
  output logic o_pop_valid,
  output logic [31:0] o_stack_pointer_wide,
  output logic [15:0] o_stack_pointer_narrow,
  output logic [15:0] o_stack_sel,
  output logic o_explicit_wide
);
  import stack_unit_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } phase_t;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  phase_t phase_reg;
  logic [31:0] sp_reg;
  logic [31:0] sp_next;
  logic [15:0] sel_reg;
  logic [31:0] wdata_reg;
  logic [31:0] pop_reg;
  logic pop_valid_reg;
  logic req_reg;
  logic we_reg;
  logic [31:0] addr_reg;
  logic narrow_reg;
  logic wide_stack;
  logic narrow_addr;
  logic is_push;
  logic is_pop;
  logic align_sel;
  logic [31:0] step;
  logic calc_narrow;
  logic explicit_wide_reg;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // operation decode
  // ---------------------------------------------------------------
  function automatic logic op_pushes(input stack_op_t op);
    op_pushes = (op == OP_PUSH) || (op == OP_PUSH_SEL) ||
                (op == OP_CALL) || (op == OP_ENTER);
  endfunction

  function automatic logic op_pops(input stack_op_t op);
    op_pops = (op == OP_POP) || (op == OP_RET) || (op == OP_LEAVE);
  endfunction

  assign wide_stack = i_code_dflag;
  // stack big flag picks pointer size
  assign narrow_addr = !i_stack_bflag;
  // explicit operand size, prefix flips it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      explicit_wide_reg <= 1'b0;
    end else begin
      explicit_wide_reg <= i_code_dflag ^ i_addr_prefix;
    end
  end
  assign o_explicit_wide = explicit_wide_reg;
  assign is_push = i_op_valid && (phase_reg == ST_IDLE) && op_pushes(i_op);
  assign is_pop = i_op_valid && (phase_reg == ST_IDLE) && op_pops(i_op);
  // plain narrow pushes not realigned
  // gated by the push, so a pending pop never realigns
  assign align_sel = is_push && wide_stack && (i_op == OP_PUSH_SEL);
  assign step = (wide_stack && !(i_push_narrow && i_op != OP_PUSH_SEL)) ?
                STEP_WIDE : STEP_NARROW;

  // pop keeps the pointer size it was issued with
  assign calc_narrow = (phase_reg == ST_READ) ? narrow_reg : narrow_addr;

  stack_addr_calc u_calc (
    .i_sp(sp_reg),
    .i_step(step),
    .i_down(is_push),
    .i_narrow(calc_narrow),
    .i_align(align_sel),
    .o_sp(sp_next)
  );

  // ---------------------------------------------------------------
  // current stack selector
  // ---------------------------------------------------------------
  // one selector register, one current stack
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= SEL_RESET;
    end else if (i_load_sel_en && phase_reg == ST_IDLE) begin
      sel_reg <= i_load_sel;
    end
  end

  // ---------------------------------------------------------------
  // stack pointer
  // ---------------------------------------------------------------
  // pop increments only after the read data came back
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg <= SP_RESET;
      narrow_reg <= 1'b0;
    end else if (i_load_sp_en && phase_reg == ST_IDLE && !is_push &&
                 !is_pop) begin
      sp_reg <= i_load_sp;
    end else if (is_push) begin
      // decrement before the write goes out
      sp_reg <= sp_next;
    end else if (is_pop) begin
      narrow_reg <= narrow_addr;
    end else if (phase_reg == ST_READ && i_mem_rvalid) begin
      sp_reg <= sp_next;
    end
  end

  // ---------------------------------------------------------------
  // memory sequence
  // ---------------------------------------------------------------
  // misaligned pointers pass with no check
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= ST_IDLE;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= SP_RESET;
      wdata_reg <= SP_RESET;
    end else begin
      case (phase_reg)
        ST_IDLE: begin
          req_reg <= 1'b0;
          we_reg <= 1'b0;
          if (is_push) begin
            phase_reg <= ST_WRITE;
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            addr_reg <= narrow_addr ? {16'h0000, sp_next[15:0]} : sp_next;
            wdata_reg <= i_push_data;
          end else if (is_pop) begin
            phase_reg <= ST_READ;
            req_reg <= 1'b1;
            addr_reg <= narrow_addr ? {16'h0000, sp_reg[15:0]} : sp_reg;
          end
        end
        ST_WRITE: begin
          // write issued for one cycle, memory never stalls
          req_reg <= 1'b0;
          we_reg <= 1'b0;
          phase_reg <= ST_IDLE;
        end
        ST_READ: begin
          req_reg <= 1'b0;
          if (i_mem_rvalid) begin
            phase_reg <= ST_IDLE;
          end
        end
        default: begin
          phase_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pop data
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pop_reg <= SP_RESET;
      pop_valid_reg <= 1'b0;
    end else begin
      pop_valid_reg <= (phase_reg == ST_READ) && i_mem_rvalid;
      if (phase_reg == ST_READ && i_mem_rvalid) begin
        pop_reg <= i_mem_rdata;
      end
    end
  end

  // every access names the stack segment
  // all stack ops share that segment
  assign o_mem_seg = sel_reg;
  assign o_mem_req = req_reg;
  assign o_mem_we = we_reg;
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_pop_data = pop_reg;
  assign o_pop_valid = pop_valid_reg;
  // full 32-bit pointer covers the whole segment
  assign o_stack_pointer_wide = sp_reg;
  assign o_stack_pointer_narrow = sp_reg[15:0];
  assign o_stack_sel = sel_reg;
  assign o_busy = (phase_reg != ST_IDLE);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_push_dec;
    @(posedge i_clk) disable iff (!rst_n)
      is_push |=> o_mem_req && o_mem_we && o_mem_addr[15:0] == sp_reg[15:0];
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("push write not at decremented pointer");

  property p_pop_order;
    @(posedge i_clk) disable iff (!rst_n)
      is_pop |=> o_mem_req && !o_mem_we && $stable(sp_reg);
  endproperty
  a_pop_order: assert property (p_pop_order)
    else $error("pop moved pointer before read");

  property p_seg_used;
    @(posedge i_clk) disable iff (!rst_n)
      o_busy |=> o_mem_seg == $past(o_mem_seg);
  endproperty
  a_seg_used: assert property (p_seg_used)
    else $error("access outside stack segment");

  property p_wide_step;
    @(posedge i_clk) disable iff (!rst_n)
      is_push && i_op == OP_PUSH && wide_stack && !i_push_narrow &&
      !narrow_addr |=> sp_reg == $past(sp_reg) - STEP_WIDE;
  endproperty
  a_wide_step: assert property (p_wide_step)
    else $error("wide push step wrong");

  property p_narrow_step;
    @(posedge i_clk) disable iff (!rst_n)
      is_push && i_op == OP_PUSH && !wide_stack && !narrow_addr
      |=> sp_reg == $past(sp_reg) - STEP_NARROW;
  endproperty
  a_narrow_step: assert property (p_narrow_step)
    else $error("narrow push step wrong");

  property p_sel_align;
    @(posedge i_clk) disable iff (!rst_n)
      is_push && align_sel |=> sp_reg[1:0] == 2'b00;
  endproperty
  a_sel_align: assert property (p_sel_align)
    else $error("selector push left pointer unaligned");

  property p_narrow_upper;
    @(posedge i_clk) disable iff (!rst_n)
      (is_push && narrow_addr) |=> sp_reg[31:16] == $past(sp_reg[31:16]);
  endproperty
  a_narrow_upper: assert property (p_narrow_upper)
    else $error("narrow update changed upper pointer");

  property p_narrow_addr;
    @(posedge i_clk) disable iff (!rst_n)
      (is_push || is_pop) && narrow_addr |=> o_mem_addr[31:16] == 16'h0000;
  endproperty
  a_narrow_addr: assert property (p_narrow_addr)
    else $error("narrow address above 16 bits");

  property p_pop_done;
    @(posedge i_clk) disable iff (!rst_n)
      is_pop |-> ##[1:1000] !o_busy;
  endproperty
  a_pop_done: assert property (p_pop_done)
    else $error("pop never completed");
endmodule
`default_nettype wire

// File: verif/stack_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// stack memory on the far side; read latency is set by the bench
module stack_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_lat,
  output logic [31:0] o_rdata,
  output logic o_rvalid
);
  logic [31:0] mem [logic [31:0]];
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [31:0] raddr = 32'h0000_0000;
  initial o_rvalid = 1'b0;
  initial o_rdata = 32'h0000_0000;
  // writes land at once, reads answer after i_lat+1 idle cycles
  always @(posedge i_clk) begin
    o_rvalid <= 1'b0;
    // data line churns while no answer stands, so stale data never matches
    o_rdata <= ~o_rdata;
    if (i_req && i_we) begin
      mem[i_addr] = i_wdata;
    end else if (i_req) begin
      pend <= 1'b1;
      cnt <= i_lat;
      raddr <= i_addr;
    end else if (pend && cnt == 4'h0) begin
      pend <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= mem.exists(raddr) ? mem[raddr] : 32'h0000_0000;
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verif/stack_pointer_push_pop_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module stack_pointer_push_pop_unit_bench;
  import stack_unit_pkg::*;
  typedef struct {stack_op_t op; logic [31:0] d; logic nar, df, bf;
    logic [31:0] sp, ad;} row_t;
  logic i_clk, i_rst_n, i_op_valid, i_push_narrow, i_code_dflag;
  logic i_addr_prefix, i_stack_bflag, i_load_sel_en, i_load_sp_en;
  logic i_mem_rvalid, o_busy, o_mem_req, o_mem_we, o_pop_valid;
  logic o_explicit_wide, got_req, got_pop, c_we;
  stack_op_t i_op;
  logic [31:0] i_push_data, i_load_sp, i_mem_rdata, o_mem_addr, o_mem_wdata;
  logic [31:0] o_pop_data, o_stack_pointer_wide, c_addr, c_wd, c_pd;
  logic [15:0] i_load_sel, o_mem_seg, o_stack_pointer_narrow, o_stack_sel;
  logic [15:0] c_seg;
  logic [3:0] lat;
  int bad_count = 0;
  int cmp_count = 0;
  row_t rows [10] = '{
    '{OP_PUSH, 32'h0000_1111, 1, 1, 1, 32'h0001_0006, 32'h0001_0006},
    '{OP_PUSH_SEL, 32'h0000_0028, 0, 1, 1, 32'h0001_0000, 32'h0001_0000},
    '{OP_PUSH, 32'h2222_3333, 0, 1, 1, 32'h0000_FFFC, 32'h0000_FFFC},
    '{OP_POP, 32'h2222_3333, 0, 1, 1, 32'h0001_0000, 32'h0000_FFFC},
    '{OP_PUSH, 32'h4444_5555, 0, 0, 1, 32'h0000_FFFE, 32'h0000_FFFE},
    '{OP_CALL, 32'h6666_7777, 0, 1, 0, 32'h0000_FFFA, 32'h0000_FFFA},
    '{OP_RET, 32'h6666_7777, 0, 1, 0, 32'h0000_FFFE, 32'h0000_FFFA},
    '{OP_ENTER, 32'h8888_9999, 0, 1, 1, 32'h0000_FFFA, 32'h0000_FFFA},
    '{OP_LEAVE, 32'h8888_9999, 0, 1, 1, 32'h0000_FFFE, 32'h0000_FFFA},
    '{OP_LOAD, 32'h0000_0000, 0, 1, 1, 32'h0000_FFFE, 32'h0000_0000}};
  stack_pointer_push_pop_unit i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_push_data(i_push_data),
    .i_push_narrow(i_push_narrow), .i_code_dflag(i_code_dflag),
    .i_addr_prefix(i_addr_prefix), .i_stack_bflag(i_stack_bflag),
    .i_load_sel(i_load_sel), .i_load_sp(i_load_sp),
    .i_load_sel_en(i_load_sel_en), .i_load_sp_en(i_load_sp_en),
    .i_mem_rdata(i_mem_rdata), .i_mem_rvalid(i_mem_rvalid), .o_busy(o_busy),
    .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_seg(o_mem_seg),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_pop_data(o_pop_data), .o_pop_valid(o_pop_valid),
    .o_stack_pointer_wide(o_stack_pointer_wide),
    .o_stack_pointer_narrow(o_stack_pointer_narrow),
    .o_stack_sel(o_stack_sel), .o_explicit_wide(o_explicit_wide));
  stack_mem_model i_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat),
    .o_rdata(i_mem_rdata), .o_rvalid(i_mem_rvalid));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // software side sets up the stack: selector first, then pointer
  task automatic load(input logic [15:0] sel, input logic [31:0] sp);
    @(posedge i_clk);
    i_load_sel <= sel;
    i_load_sel_en <= 1'b1;
    @(posedge i_clk);
    i_load_sel_en <= 1'b0;
    i_load_sp <= sp;
    i_load_sp_en <= 1'b1;
    @(posedge i_clk);
    i_load_sp_en <= 1'b0;
  endtask
  // one operation, capturing the memory request and pop answer
  task automatic run_op(input stack_op_t op, input logic [31:0] d,
                        input logic nar, input logic df, input logic bf);
    got_req = 1'b0;
    got_pop = 1'b0;
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_push_data <= d;
    i_push_narrow <= nar;
    i_code_dflag <= df;
    i_stack_bflag <= bf;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    for (int n = 0; n < 20; n++) begin
      #1;
      if (o_mem_req === 1'b1) begin
        got_req = 1'b1;
        c_addr = o_mem_addr;
        c_we = o_mem_we;
        c_wd = o_mem_wdata;
        c_seg = o_mem_seg;
      end
      if (o_pop_valid === 1'b1) begin
        got_pop = 1'b1;
        c_pd = o_pop_data;
      end
      if (n > 0 && o_busy === 1'b0) break;
      @(posedge i_clk);
    end
  endtask
  initial begin
    #150000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {i_rst_n, i_op_valid, i_push_narrow, i_code_dflag} = 4'h0;
    {i_addr_prefix, i_stack_bflag, i_load_sel_en, i_load_sp_en} = 4'h0;
    i_op = OP_LOAD;
    {i_push_data, i_load_sp, i_load_sel} = 80'h0;
    lat = 4'h0;
    repeat (4) @(posedge i_clk);
    `CHK({o_busy, o_mem_req, o_stack_pointer_wide}, 34'h0)
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    load(16'h0028, 32'h0001_0008);
    // table of ordinary operations, each row continues the previous
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].d, rows[i].nar, rows[i].df, rows[i].bf);
      `CHK(o_stack_pointer_wide, rows[i].sp)
      `CHK(o_stack_pointer_narrow, rows[i].sp[15:0])
      `CHK(got_req, rows[i].op != OP_LOAD)
      if (rows[i].op != OP_LOAD) begin
        `CHK(c_addr, rows[i].ad)
        `CHK(c_seg, 16'h0028)
        `CHK(c_we, !(rows[i].op inside {OP_POP, OP_RET, OP_LEAVE}))
      end
      if (rows[i].op inside {OP_PUSH, OP_PUSH_SEL, OP_CALL, OP_ENTER}) begin
        `CHK(c_wd, rows[i].d)
      end
      if (rows[i].op inside {OP_POP, OP_RET, OP_LEAVE}) begin
        `CHK({got_pop, c_pd}, {1'b1, rows[i].d})
      end
    end
    // narrow pointer wraps in 16 bits and keeps its upper half
    load(16'h0030, 32'h0005_0002);
    run_op(OP_PUSH, 32'hABCD_0123, 1'b0, 1'b1, 1'b0);
    `CHK(o_stack_pointer_wide, 32'h0005_FFFE)
    `CHK(c_addr, 32'h0000_FFFE)
    `CHK(o_stack_sel, 16'h0030)
    run_op(OP_POP, 32'h0, 1'b0, 1'b1, 1'b0);
    `CHK({o_stack_pointer_wide, c_pd}, 64'h0005_0002_ABCD_0123)
    // wide pointer over the full range; misaligned start gives no fault
    load(16'h0030, 32'h0000_0001);
    run_op(OP_PUSH, 32'h1357_9BDF, 1'b0, 1'b1, 1'b1);
    `CHK(o_stack_pointer_wide, 32'hFFFF_FFFD)
    `CHK(c_addr, 32'hFFFF_FFFD)
    // slow memory; op and load during busy are ignored
    lat = 4'h4;
    load(16'h0030, 32'h0000_0100);
    run_op(OP_POP, 32'h0, 1'b0, 1'b1, 1'b1);
    // empty memory word reads back as zero after the long wait
    `CHK({got_pop, c_pd}, 33'h1_0000_0000)
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= OP_POP;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    @(posedge i_clk);
    i_op <= OP_PUSH;
    i_op_valid <= 1'b1;
    i_load_sp <= 32'h0000_0F00;
    i_load_sp_en <= 1'b1;
    @(posedge i_clk);
    {i_op_valid, i_load_sp_en} <= 2'b00;
    repeat (12) @(posedge i_clk);
    #1;
    `CHK(o_stack_pointer_wide, 32'h0000_0108)
    // explicit operand size from code flag and prefix
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      {i_code_dflag, i_addr_prefix} <= 2'(k);
      @(posedge i_clk);
      #1;
      `CHK(o_explicit_wide, ^2'(k))
    end
    // second reset in mid-run: state drops back, first push after works
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK({o_stack_pointer_wide, o_stack_sel, o_busy}, 49'h0)
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    run_op(OP_PUSH, 32'h0000_0042, 1'b0, 1'b1, 1'b1);
    `CHK(o_stack_pointer_wide, 32'hFFFF_FFFC)
    `CHK(c_addr, 32'hFFFF_FFFC)
    give_verdict();
  end
endmodule
`default_nettype wire
